// ==== rtl/tsl_loop_ctrl.sv ====
/*
  Control and status registers of a time-sync channel loop filter.
  Assumes a one-cycle write/read strobe port and a filter datapath that
  consumes the control outputs and supplies state and readback values.
*/
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "tsl_cfg.svh"

// Summary of operation
// [RULE1] Filter calculations stop while the inhibit bit is 1; it resets to 1.
// [RULE2] Software sets inhibit before changing filter settings, clears it afterwards.
// [RULE3] Writing 1 to bit 1 of the clear register resets the holdover filter.
// [RULE4] Writing 1 to bit 0 of the clear register resets holdover history.
// [RULE5] Force select bit 36 takes holdover frequency from software instead.
// [RULE6] Forced holdover value sits in bits 32:0, used only when selected.
// [RULE7] Frequency override word is 33-bit two's complement, LSB 2^-44 ppm*1e6.
// [RULE8] Software keeps the fractional output divider fractional when overriding.
// [RULE9] Timed frequency write with enable applies its offset for the duration.
// [RULE10] On timer expiry the offset returns to the frequency override word.
// [RULE11] Loop state code reads in status bits 42:40.
// [RULE12] Status bits 38:0 return the quantity picked by the readback select.
// [RULE13] Timer status bits 15:0 show the live override timer count.
// [RULE14] Software writes phase or frequency overrides only while timer reads 0.
// [RULE15] Readback select: 0 integrator, 1 frequency offset, 2 holdover, 3 reserved.
// [RULE16] Override duration is a 16-bit count of milliseconds.
// [RULE17] The loop filter runs only while its enable bit is set.
// [RULE18] Timer loads the duration on start and counts down each millisecond.
module tsl_loop_ctrl #(
  parameter int MS_CYCLES = `TSL_MS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [63:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [63:0] rd_data,
  input  wire logic [2:0]  loop_state,
  input  wire logic [38:0] integ_val,
  input  wire logic [38:0] freq_ofs_val,
  input  wire logic [38:0] hold_calc_val,
  input  wire logic [32:0] hold_calc_freq,
  output logic             filter_run,
  output logic             smoother_clear,
  output logic             record_clear,
  output logic      [32:0] hold_freq,
  output logic      [32:0] freq_offset,
  output logic      [27:0] phase_word,
  output logic             phase_apply
);

  tsl_pkg::tsl_regs_st_t s_r;
  tsl_pkg::tsl_regs_st_t s_nxt;

  logic        tick;
  logic        tmr_start;
  logic        fr_start;
  logic        ph_start;
  logic [15:0] tmr_count;
  logic        tmr_expired;
  logic [38:0] rb_val;

  // ----------------------------------------
  // Override timing
  // ----------------------------------------
  // Timed writes with a zero duration only store the word
  assign fr_start  = wr_en && addr == `TSL_OFS_TFREQ && s_r.fr_tmr_en && s_r.dur != 16'h0; // RULE9
  assign ph_start  = wr_en && addr == `TSL_OFS_PHASE && s_r.ph_tmr_en && s_r.dur != 16'h0;
  assign tmr_start = fr_start || ph_start;

  tsl_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) i_tsl_ms_tick (
    .clock   (clock),
    .rst     (rst),
    .restart (tmr_start),
    .tick    (tick)
  );

  tsl_override_timer i_tsl_override_timer (
    .clock   (clock),
    .rst     (rst),
    .start   (tmr_start),
    .load    (s_r.dur),
    .tick    (tick),
    .count   (tmr_count),
    .expired (tmr_expired)
  );

  // ----------------------------------------
  // Readback source
  // ----------------------------------------
  always_comb
  begin
    rb_val = 39'h0;
    case (s_r.rb_sel) // RULE15
      tsl_pkg::TSL_RB_INTEG: rb_val = integ_val;
      tsl_pkg::TSL_RB_FREQ:  rb_val = freq_ofs_val;
      tsl_pkg::TSL_RB_HOLD:  rb_val = hold_calc_val;
      default:               rb_val = 39'h0;
    endcase
  end

  // ----------------------------------------
  // Register file and outputs
  // ----------------------------------------
  always_comb
  begin
    s_nxt            = s_r;
    s_nxt.smooth_clr = 1'b0;
    s_nxt.record_clr = 1'b0;
    if (wr_en)
    begin
      if (addr == `TSL_OFS_INHIBIT)
        s_nxt.inhibit = wr_data[`TSL_INHIBIT_BIT];
      else if (addr == `TSL_OFS_HOLD_CLR)
      begin
        s_nxt.smooth_clr = wr_data[`TSL_SMOOTH_CLR_BIT]; // RULE3
        s_nxt.record_clr = wr_data[`TSL_RECORD_CLR_BIT]; // RULE4
      end
      else if (addr == `TSL_OFS_HOLD_FORCE)
      begin
        s_nxt.force_sel = wr_data[`TSL_FORCE_SEL_BIT];
        s_nxt.force_val = wr_data[`TSL_WORD_MSB:0]; // RULE6
      end
      else if (addr == `TSL_OFS_PHASE)
        s_nxt.phase = wr_data[`TSL_PHASE_MSB:0];
      else if (addr == `TSL_OFS_FREQ)
        s_nxt.freq = wr_data[`TSL_WORD_MSB:0]; // RULE7
      else if (addr == `TSL_OFS_TFREQ)
        s_nxt.tfreq = wr_data[`TSL_WORD_MSB:0];
      else if (addr == `TSL_OFS_LOOP_CTRL)
      begin
        s_nxt.enable = wr_data[`TSL_ENABLE_BIT];
        s_nxt.rb_sel = tsl_pkg::tsl_rb_sel_t'(wr_data[`TSL_RB_SEL_MSB:`TSL_RB_SEL_LSB]);
      end
      else if (addr == `TSL_OFS_TMR_CTRL)
      begin
        s_nxt.dur       = wr_data[`TSL_DUR_MSB:0]; // RULE16
        s_nxt.ph_tmr_en = wr_data[`TSL_PH_TMR_EN_BIT];
        s_nxt.fr_tmr_en = wr_data[`TSL_FR_TMR_EN_BIT];
      end
    end

    // A new start beats an expiry seen in the same cycle
    if (fr_start)
    begin
      s_nxt.freq_timed  = 1'b1; // RULE9
      s_nxt.phase_timed = 1'b0;
    end
    else if (ph_start)
    begin
      s_nxt.freq_timed  = 1'b0;
      s_nxt.phase_timed = 1'b1;
    end
    else if (tmr_expired)
    begin
      s_nxt.freq_timed  = 1'b0; // RULE10
      s_nxt.phase_timed = 1'b0;
    end

    s_nxt.run       = s_nxt.enable && !s_nxt.inhibit; // RULE1 RULE17
    s_nxt.hold_freq = s_nxt.force_sel ? s_nxt.force_val : hold_calc_freq; // RULE5
    s_nxt.freq_ofs  = s_nxt.freq_timed ? s_nxt.tfreq : s_nxt.freq; // RULE10

    s_nxt.rd_data = 64'h0;
    if (rd_en)
    begin
      if (addr == `TSL_OFS_INHIBIT)
        s_nxt.rd_data[`TSL_INHIBIT_BIT] = s_r.inhibit;
      else if (addr == `TSL_OFS_HOLD_FORCE)
      begin
        s_nxt.rd_data[`TSL_FORCE_SEL_BIT] = s_r.force_sel;
        s_nxt.rd_data[`TSL_WORD_MSB:0]    = s_r.force_val;
      end
      else if (addr == `TSL_OFS_PHASE)
        s_nxt.rd_data[`TSL_PHASE_MSB:0] = s_r.phase;
      else if (addr == `TSL_OFS_FREQ)
        s_nxt.rd_data[`TSL_WORD_MSB:0] = s_r.freq;
      else if (addr == `TSL_OFS_TFREQ)
        s_nxt.rd_data[`TSL_WORD_MSB:0] = s_r.tfreq;
      else if (addr == `TSL_OFS_STATUS)
      begin
        s_nxt.rd_data[`TSL_STATE_MSB:`TSL_STATE_LSB] = loop_state; // RULE11
        s_nxt.rd_data[`TSL_RB_MSB:0]                 = rb_val; // RULE12
      end
      else if (addr == `TSL_OFS_TMR_STS)
        s_nxt.rd_data[`TSL_DUR_MSB:0] = tmr_count; // RULE13
      else if (addr == `TSL_OFS_LOOP_CTRL)
      begin
        s_nxt.rd_data[`TSL_ENABLE_BIT]                 = s_r.enable;
        s_nxt.rd_data[`TSL_RB_SEL_MSB:`TSL_RB_SEL_LSB] = s_r.rb_sel;
      end
      else if (addr == `TSL_OFS_TMR_CTRL)
      begin
        s_nxt.rd_data[`TSL_DUR_MSB:0]      = s_r.dur;
        s_nxt.rd_data[`TSL_PH_TMR_EN_BIT] = s_r.ph_tmr_en;
        s_nxt.rd_data[`TSL_FR_TMR_EN_BIT] = s_r.fr_tmr_en;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r         <= '0;
      s_r.inhibit <= `TSL_INHIBIT_RST; // RULE1
      s_r.enable  <= `TSL_ENABLE_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign rd_data        = s_r.rd_data;
  assign filter_run     = s_r.run;
  assign smoother_clear = s_r.smooth_clr;
  assign record_clear   = s_r.record_clr;
  assign hold_freq      = s_r.hold_freq;
  assign freq_offset    = s_r.freq_ofs;
  assign phase_word     = s_r.phase;
  assign phase_apply    = s_r.phase_timed;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_inhibit_stops_run: assert property (
    wr_en && addr == `TSL_OFS_INHIBIT && wr_data[0] |=> !filter_run && s_r.inhibit) // RULE1
    else $error("filter ran while inhibited");

  chk_enable_gates_run: assert property (filter_run |-> s_r.enable && !s_r.inhibit) // RULE17
    else $error("filter ran while disabled");

  chk_smoother_pulse: assert property (
    wr_en && addr == `TSL_OFS_HOLD_CLR && wr_data[1] |=> smoother_clear
    ##1 (!smoother_clear || $past(wr_en && addr == `TSL_OFS_HOLD_CLR && wr_data[1]))) // RULE3
    else $error("holdover filter clear not a single pulse");

  chk_record_pulse: assert property (
    wr_en && addr == `TSL_OFS_HOLD_CLR && wr_data[0] |=> record_clear
    ##1 (!record_clear || $past(wr_en && addr == `TSL_OFS_HOLD_CLR && wr_data[0]))) // RULE4
    else $error("holdover history clear not a single pulse");

  // The cycle after reset still shows the reset value, not the delayed input
  chk_force_holdover: assert property (
    !$past(rst) |-> hold_freq == (s_r.force_sel ? s_r.force_val : $past(hold_calc_freq))) // RULE5
    else $error("holdover frequency source wrong");

  chk_timed_apply: assert property (
    fr_start |=> freq_offset == $past(wr_data[32:0])) // RULE9
    else $error("timed offset not applied");

  chk_revert_on_expiry: assert property (
    tmr_expired && !tmr_start |=> freq_offset == s_r.freq) // RULE10
    else $error("offset did not revert on expiry");

  chk_state_readback: assert property (
    rd_en && addr == `TSL_OFS_STATUS |=> rd_data[42:40] == $past(loop_state) && rd_data[39] == 1'b0) // RULE11
    else $error("loop state readback wrong");

  chk_select_readback: assert property (
    rd_en && addr == `TSL_OFS_STATUS && s_r.rb_sel == tsl_pkg::TSL_RB_FREQ
    |=> rd_data[38:0] == $past(freq_ofs_val)) // RULE12
    else $error("readback source wrong");

  chk_timer_readback: assert property (
    rd_en && addr == `TSL_OFS_TMR_STS |=> rd_data == {48'h0, $past(tmr_count)}) // RULE13
    else $error("timer status readback wrong");

endmodule

// ==== rtl/tsl_cfg.svh ====
/*
  Offsets, field positions, reset values and timing counts of the
  time-sync loop filter control block.
  Assumes a 50 MHz system clock and a word-indexed register port.
*/
`ifndef TSL_CFG_SVH
`define TSL_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSL_OFS_INHIBIT    4'h0
`define TSL_OFS_HOLD_CLR   4'h1
`define TSL_OFS_HOLD_FORCE 4'h2
`define TSL_OFS_PHASE      4'h3
`define TSL_OFS_FREQ       4'h4
`define TSL_OFS_TFREQ      4'h5
`define TSL_OFS_STATUS     4'h6
`define TSL_OFS_TMR_STS    4'h7
`define TSL_OFS_LOOP_CTRL  4'h8
`define TSL_OFS_TMR_CTRL   4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSL_INHIBIT_BIT    0
`define TSL_SMOOTH_CLR_BIT 1
`define TSL_RECORD_CLR_BIT 0
`define TSL_FORCE_SEL_BIT  36
`define TSL_WORD_MSB       32
`define TSL_PHASE_MSB      27
`define TSL_STATE_LSB      40
`define TSL_STATE_MSB      42
`define TSL_RB_MSB         38
`define TSL_ENABLE_BIT     0
`define TSL_RB_SEL_LSB     2
`define TSL_RB_SEL_MSB     3
`define TSL_DUR_MSB        15
`define TSL_PH_TMR_EN_BIT  16
`define TSL_FR_TMR_EN_BIT  17

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSL_INHIBIT_RST    1'b1
`define TSL_ENABLE_RST     1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSL_CLK_PERIOD_NS  20
`define TSL_MS_NS          1000000
`define TSL_MS_CYCLES      (`TSL_MS_NS / `TSL_CLK_PERIOD_NS)

`endif

// ==== rtl/tsl_pkg.sv ====
/*
  Types shared by the time-sync loop filter control modules.
  Assumes the constants of tsl_cfg.svh for field widths.
*/
package tsl_pkg;

  typedef enum logic [1:0] {
    TSL_TMR_IDLE = 2'b01,
    TSL_TMR_RUN  = 2'b10
  } tsl_tmr_state_t;

  typedef enum logic [1:0] {
    TSL_RB_INTEG = 2'h0,
    TSL_RB_FREQ  = 2'h1,
    TSL_RB_HOLD  = 2'h2,
    TSL_RB_RSVD  = 2'h3
  } tsl_rb_sel_t;

  typedef struct packed {
    logic [19:0] cnt;
    logic        tick;
  } tsl_tick_st_t;

  typedef struct packed {
    tsl_tmr_state_t state;
    logic [15:0]    count;
    logic           expired;
  } tsl_tmr_st_t;

  typedef struct packed {
    logic        inhibit;
    logic        enable;
    tsl_rb_sel_t rb_sel;
    logic [15:0] dur;
    logic        ph_tmr_en;
    logic        fr_tmr_en;
    logic        force_sel;
    logic [32:0] force_val;
    logic [27:0] phase;
    logic [32:0] freq;
    logic [32:0] tfreq;
    logic        freq_timed;
    logic        phase_timed;
    logic        run;
    logic        smooth_clr;
    logic        record_clr;
    logic [32:0] hold_freq;
    logic [32:0] freq_ofs;
    logic [63:0] rd_data;
  } tsl_regs_st_t;

endpackage

// ==== rtl/tsl_ms_tick.sv ====
/*
  Millisecond enable divider: one-cycle tick every CYCLES clocks.
  Assumes restart is a one-cycle pulse from the control block.
*/
`timescale 1ns/1ps
`include "tsl_cfg.svh"

module tsl_ms_tick #(
  parameter int CYCLES = `TSL_MS_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);

  tsl_pkg::tsl_tick_st_t s_r;
  tsl_pkg::tsl_tick_st_t s_nxt;

  // Restart realigns the phase so a timed override lasts whole milliseconds
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (restart || s_r.cnt == 20'h0)
    begin
      s_nxt.cnt  = 20'(CYCLES - 1);
      s_nxt.tick = ~restart;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt - 20'h1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

  chk_tick_single: assert property (@(posedge clock) disable iff (rst) tick |=> !tick)
    else $error("tick longer than one cycle");

endmodule

// ==== rtl/tsl_override_timer.sv ====
/*
  Override timer: loads a duration in ms and counts down on each tick.
  Assumes start is a one-cycle pulse with load nonzero.
*/
`timescale 1ns/1ps

module tsl_override_timer (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] load,
  input  wire logic        tick,
  output logic      [15:0] count,
  output logic             expired
);

  tsl_pkg::tsl_tmr_st_t s_r;
  tsl_pkg::tsl_tmr_st_t s_nxt;

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.expired = 1'b0;
    case (s_r.state)
      tsl_pkg::TSL_TMR_IDLE:
      begin
        if (start && load != 16'h0)
        begin
          s_nxt.count = load; // RULE18
          s_nxt.state = tsl_pkg::TSL_TMR_RUN;
        end
      end
      tsl_pkg::TSL_TMR_RUN:
      begin
        if (start && load != 16'h0)
        begin
          s_nxt.count = load;
        end
        else if (tick)
        begin
          s_nxt.count = s_r.count - 16'h1; // RULE18
          if (s_r.count == 16'h1)
          begin
            s_nxt.state   = tsl_pkg::TSL_TMR_IDLE;
            s_nxt.expired = 1'b1;
          end
        end
      end
      default:
      begin
        s_nxt.state = tsl_pkg::TSL_TMR_IDLE;
        s_nxt.count = 16'h0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r         <= '0;
      s_r.state   <= tsl_pkg::TSL_TMR_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign count   = s_r.count;
  assign expired = s_r.expired;

  chk_timer_load: assert property (@(posedge clock) disable iff (rst)
    start && load != 16'h0 |=> count == $past(load)) // RULE18
    else $error("timer did not load duration");

  chk_timer_step: assert property (@(posedge clock) disable iff (rst)
    tick && !start && count != 16'h0 |=> count == $past(count) - 16'h1) // RULE18
    else $error("timer did not step once per tick");

endmodule

// ==== verification/tsl_loop_ctrl_tb.sv ====
/*
  Self-checking testbench of the time-sync loop filter control registers.
  Assumes the offsets and field positions of tsl_cfg.svh and a shortened ms tick.
*/
`timescale 1ns/1ps
`include "tsl_cfg.svh"

module tsl_loop_ctrl_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // A short ms tick keeps the override timing inside a few dozen cycles
  localparam int MS = 4;
  logic        clock;
  logic        rst;
  logic [3:0]  addr;
  logic [63:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [63:0] rd_data;
  logic [2:0]  loop_state;
  logic [38:0] integ_val;
  logic [38:0] freq_ofs_val;
  logic [38:0] hold_calc_val;
  logic [32:0] hold_calc_freq;
  logic        filter_run;
  logic        smoother_clear;
  logic        record_clear;
  logic [32:0] hold_freq;
  logic [32:0] freq_offset;
  logic [27:0] phase_word;
  logic        phase_apply;
  logic [38:0] rb;
  int          miscompares;
  int          samples_checked;
  int          n;

  tsl_loop_ctrl #(.MS_CYCLES(MS)) i_tsl_loop_ctrl (
    .clock          (clock),
    .rst            (rst),
    .addr           (addr),
    .wr_data        (wr_data),
    .wr_en          (wr_en),
    .rd_en          (rd_en),
    .rd_data        (rd_data),
    .loop_state     (loop_state),
    .integ_val      (integ_val),
    .freq_ofs_val   (freq_ofs_val),
    .hold_calc_val  (hold_calc_val),
    .hold_calc_freq (hold_calc_freq),
    .filter_run     (filter_run),
    .smoother_clear (smoother_clear),
    .record_clear   (record_clear),
    .hold_freq      (hold_freq),
    .freq_offset    (freq_offset),
    .phase_word     (phase_word),
    .phase_apply    (phase_apply)
  );

  always #10 clock = ~clock;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Write ends just past the taking edge, so outputs can be looked at at once
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [63:0] exp);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(name, rd_data, exp);
  endtask

  task automatic bound_fail();
    miscompares++;
    print_verdict();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clock          = 1'b0;
    rst            = 1'b1;
    addr           = 4'h0;
    wr_data        = 64'h0;
    wr_en          = 1'b0;
    rd_en          = 1'b0;
    loop_state     = 3'h0;
    integ_val      = 39'h11_2233_4455;
    freq_ofs_val   = 39'h66_7788_99aa;
    hold_calc_val  = 39'h5b_ccdd_eeff;
    hold_calc_freq = 33'h1_2345_6789;
    miscompares    = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;

    rd_chk("inhibit_reset", `TSL_OFS_INHIBIT, 64'h1);
    chk("run_after_reset", 64'(filter_run), 64'h0);
    rd_chk("force_reset", `TSL_OFS_HOLD_FORCE, 64'h0);
    rd_chk("freq_reset", `TSL_OFS_FREQ, 64'h0);
    rd_chk("tmr_reset", `TSL_OFS_TMR_STS, 64'h0);
    rd_chk("clr_read", `TSL_OFS_HOLD_CLR, 64'h0);
    wr(4'ha, 64'hffff_ffff_ffff_ffff);
    rd_chk("unmapped", 4'ha, 64'h0);

    // Enable while inhibited must not start the filter
    wr(`TSL_OFS_LOOP_CTRL, 64'h1);
    chk("run_inhibited", 64'(filter_run), 64'h0);
    wr(`TSL_OFS_INHIBIT, 64'hffff_ffff_ffff_fffe);
    chk("run_enabled", 64'(filter_run), 64'h1);
    rd_chk("inhibit_rsvd", `TSL_OFS_INHIBIT, 64'h0);
    wr(`TSL_OFS_INHIBIT, 64'h1);
    chk("run_stopped", 64'(filter_run), 64'h0);
    wr(`TSL_OFS_INHIBIT, 64'h0);
    wr(`TSL_OFS_LOOP_CTRL, 64'h0);
    chk("run_disabled", 64'(filter_run), 64'h0);

    wr(`TSL_OFS_HOLD_CLR, 64'h2);
    chk("smooth_pulse", {62'h0, smoother_clear, record_clear}, 64'h2);
    @(posedge clock);
    #1;
    chk("smooth_end", {62'h0, smoother_clear, record_clear}, 64'h0);
    wr(`TSL_OFS_HOLD_CLR, 64'h1);
    chk("record_pulse", {62'h0, smoother_clear, record_clear}, 64'h1);
    @(posedge clock);
    #1;
    chk("record_end", {62'h0, smoother_clear, record_clear}, 64'h0);

    chk("hold_calc", 64'(hold_freq), 64'h1_2345_6789);
    wr(`TSL_OFS_HOLD_FORCE, 64'hffff_fffe_0000_00aa);
    @(posedge clock);
    #1;
    chk("hold_forced", 64'(hold_freq), 64'h0_0000_00aa);
    rd_chk("force_rsvd", `TSL_OFS_HOLD_FORCE, 64'h10_0000_00aa);
    wr(`TSL_OFS_HOLD_FORCE, 64'h0_0000_00aa);
    @(posedge clock);
    #1;
    chk("hold_unforced", 64'(hold_freq), 64'h1_2345_6789);

    // Status: loop states 0 to 5 and every readback select
    for (int i = 0; i < 6; i++)
    begin
      loop_state <= 3'(i);
      wr(`TSL_OFS_LOOP_CTRL, 64'((i % 4) << 2));
      rb = (i % 4 == 0) ? integ_val : (i % 4 == 1) ? freq_ofs_val : (i % 4 == 2) ? hold_calc_val : 39'h0;
      rd_chk("status", `TSL_OFS_STATUS, {21'h0, 3'(i), 1'b0, rb});
    end

    // Frequency word is negative here, to see all 33 bits pass
    wr(`TSL_OFS_FREQ, 64'hffff_ffff_ffff_ffff);
    chk("freq_word", 64'(freq_offset), 64'h1_ffff_ffff);
    rd_chk("freq_rsvd", `TSL_OFS_FREQ, 64'h1_ffff_ffff);

    // Timed write without enable only stores the value
    wr(`TSL_OFS_TFREQ, 64'h1234);
    chk("tfreq_off", 64'(freq_offset), 64'h1_ffff_ffff);
    wr(`TSL_OFS_TMR_CTRL, 64'h2_0003);
    wr(`TSL_OFS_TFREQ, 64'h1234);
    chk("tfreq_on", 64'(freq_offset), 64'h1234);
    rd_chk("tmr_loaded", `TSL_OFS_TMR_STS, 64'h3);
    n = 2;
    while (freq_offset === 33'h1234 && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 40)
      bound_fail();
    // Three ms of MS cycles each, plus the two-cycle tick and expiry return lag
    chk("tfreq_span", 64'(n >= 3 * MS && n <= 3 * MS + 2), 64'h1);
    chk("freq_back", 64'(freq_offset), 64'h1_ffff_ffff);
    rd_chk("tmr_done", `TSL_OFS_TMR_STS, 64'h0);

    wr(`TSL_OFS_TMR_CTRL, 64'h1_0002);
    wr(`TSL_OFS_PHASE, 64'hffff_ffff_f123_4567);
    chk("phase_on", {35'h0, phase_apply, phase_word}, {36'h1, 28'h123_4567});
    n = 0;
    while (phase_apply === 1'b1 && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 40)
      bound_fail();
    chk("phase_span", 64'(n >= 2 * MS - 1 && n <= 2 * MS + 2), 64'h1);
    rd_chk("phase_rsvd", `TSL_OFS_PHASE, 64'h123_4567);
    print_verdict();
  end
endmodule
